//--- rtl/dual_stage_start_sequencer.sv
`timescale 1ns/100ps
module dual_stage_start_sequencer #(
  parameter int unsigned SAMPLE_CYC = seq_pkg::MODE_SAMPLE_CYC,
  parameter int unsigned START_CYC = seq_pkg::START_DELAY_CYC,
  parameter int unsigned RESTART_CYC = seq_pkg::RESTART_CYC
) (
  // clock and reset
  input logic ref_clk,
  input logic rstn,
  // register bus
  input seq_pkg::axil_req_s axi_req,
  output seq_pkg::axil_rsp_s axi_rsp,
  // comparator levels, asynchronous
  input seq_pkg::cmp_s cmp_raw,
  // start-up fet and stage enables
  output logic startup_fet_gate,
  output logic pfc_run,
  output logic llc_run,
  // half-bridge gate drive
  output logic gate_out_first,
  output logic gate_out_second
);
  localparam int TW = seq_pkg::TMR_W;

  typedef struct packed {
    seq_pkg::cmp_s s1;
    seq_pkg::cmp_s s2;
    seq_pkg::seq_state_e st;
    logic mode_self;
    logic [TW-1:0] tmr;
    logic fet;
    logic pfc;
    logic llc;
    logic [1:0] ev;
    logic ext_drv;
    logic sw_en;
    logic [15:0] half;
    logic [7:0] dead;
    logic aw_hold;
    logic [7:0] awaddr;
    logic w_hold;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } seq_s;

  seq_s r;
  seq_s n;
  seq_pkg::cmp_s c;
  logic burst;
  logic aw_rdy;
  logic w_rdy;
  logic ar_rdy;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic addr_hit(input logic [7:0] a);
    return (a == seq_pkg::ADDR_CTRL) || (a == seq_pkg::ADDR_HALF) ||
           (a == seq_pkg::ADDR_DEAD) || (a == seq_pkg::ADDR_STATUS) ||
           (a == seq_pkg::ADDR_EVENT);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] w,
                                        input logic [3:0] s);
    logic [31:0] m;
    m = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        m[8*i +: 8] = w[8*i +: 8];
      end
    end
    return m;
  endfunction

  // only the second synchroniser stage feeds the sequencer
  assign c = r.s2;
  assign aw_rdy = !r.aw_hold && !r.bvalid;
  assign w_rdy = !r.w_hold && !r.bvalid;
  assign ar_rdy = !r.rvalid;

  // ---------------------------------------------------------------
  // sequencer and register slave
  // ---------------------------------------------------------------
  always_comb begin
    logic [1:0] ev_set;
    logic [1:0] ev_clr;
    logic [31:0] ctrl_w;
    logic [31:0] stat_w;
    logic [31:0] wm;
    logic uv;
    ev_set = 2'h0;
    ev_clr = 2'h0;
    ctrl_w = 32'h0000_0000;
    ctrl_w[seq_pkg::CTRL_EXT_BIT] = r.ext_drv;
    ctrl_w[seq_pkg::CTRL_EN_BIT] = r.sw_en;
    stat_w = 32'h0000_0000;
    stat_w[seq_pkg::ST_MODE_BIT] = r.mode_self;
    stat_w[seq_pkg::ST_FET_BIT] = r.fet;
    stat_w[seq_pkg::ST_PFC_BIT] = r.pfc;
    stat_w[seq_pkg::ST_LLC_BIT] = r.llc;
    // soft resonant start only means something through a transformer
    stat_w[seq_pkg::ST_SMOOTH_BIT] = !r.ext_drv; // RULE20
    stat_w[seq_pkg::ST_BURST_BIT] = burst;
    stat_w[seq_pkg::ST_STATE_LSB +: 4] = r.st;
    wm = 32'h0000_0000;
    n = r;
    n.s1 = cmp_raw;
    n.s2 = r.s1;
    n.tmr = r.tmr + {{(TW-1){1'b0}}, 1'b1};
    // undervoltage level depends on the latched mode
    uv = r.mode_self ? (!c.bias_above_sb_uv || !c.bias_above_sb_stop)
                     : !c.bias_above_ab_uv; // RULE11

    case (r.st)
      seq_pkg::S_IDLE: begin
        n.fet = 1'b1;
        n.pfc = 1'b0;
        n.llc = 1'b0;
        n.tmr = '0;
        if (c.bias_above_start) begin
          n.fet = 1'b0; // RULE7
          n.st = seq_pkg::S_SAMPLE;
        end
      end
      seq_pkg::S_SAMPLE: begin
        if (!c.bias_above_start) begin
          n.st = seq_pkg::S_IDLE;
        end else if (!c.pin_below_selsb) begin
          n.mode_self = 1'b1; // RULE22
          n.fet = 1'b1; // RULE8
          n.st = seq_pkg::S_SB_CHARGE;
        end else if (r.tmr == TW'(SAMPLE_CYC - 1)) begin
          n.mode_self = 1'b0; // RULE1
          n.st = seq_pkg::S_AUX_WAIT;
        end
      end
      seq_pkg::S_AUX_WAIT: begin
        n.tmr = '0;
        if (uv) begin
          n.st = seq_pkg::S_UV_HOLD;
        end else if (c.pin_above_first_run && r.sw_en) begin
          n.st = seq_pkg::S_AUX_RAMP;
        end
      end
      seq_pkg::S_AUX_RAMP: begin
        // start-up settling before the stages are released
        if (uv) begin
          n.st = seq_pkg::S_UV_HOLD;
        end else if (!c.pin_above_first_run || !r.sw_en) begin
          n.st = seq_pkg::S_AUX_WAIT;
        end else if (r.tmr == TW'(START_CYC - 1)) begin
          n.st = seq_pkg::S_AUX_RUN; // RULE6
          n.pfc = 1'b1;
          n.llc = c.pin_above_both_run;
          ev_set[seq_pkg::EV_RUN_BIT] = 1'b1;
        end
      end
      seq_pkg::S_AUX_RUN: begin
        n.pfc = c.pin_above_first_run; // RULE2
        n.llc = c.pin_above_both_run; // RULE3
        if (uv) begin
          n.pfc = 1'b0; // RULE11
          n.llc = 1'b0;
          n.st = seq_pkg::S_UV_HOLD;
        end else if (!c.pin_above_first_run || !r.sw_en) begin
          n.pfc = 1'b0;
          n.llc = 1'b0;
          n.st = seq_pkg::S_AUX_WAIT;
        end
      end
      seq_pkg::S_SB_CHARGE: begin
        n.fet = 1'b1;
        if (c.bias_above_sb_charge) begin
          n.fet = 1'b0; // RULE9
          n.st = seq_pkg::S_SB_QUAL;
        end
      end
      seq_pkg::S_SB_QUAL: begin
        // stages wait for line current and a sane bulk reading
        if (uv) begin
          n.st = seq_pkg::S_UV_HOLD;
        end else if (c.line_current_ok && c.bulk_above_peak && r.sw_en) begin
          n.pfc = 1'b1; // RULE9
          n.llc = 1'b1;
          n.st = seq_pkg::S_SB_RUN;
          ev_set[seq_pkg::EV_RUN_BIT] = 1'b1;
        end
      end
      seq_pkg::S_SB_RUN: begin
        if (uv || !r.sw_en) begin
          n.pfc = 1'b0; // RULE11
          n.llc = 1'b0;
          n.st = seq_pkg::S_UV_HOLD;
        end else begin
          n.pfc = 1'b1; // RULE10
          n.llc = 1'b1;
        end
      end
      seq_pkg::S_UV_HOLD: begin
        n.pfc = 1'b0;
        n.llc = 1'b0;
        if (r.tmr != TW'(RESTART_CYC - 1)) begin
          n.tmr = r.tmr + {{(TW-1){1'b0}}, 1'b1}; // RULE21
        end else if (r.mode_self) begin
          n.fet = 1'b1; // RULE13
          n.st = seq_pkg::S_SB_CHARGE;
        end else if (c.bias_above_ab_uv) begin
          n.st = seq_pkg::S_AUX_WAIT; // RULE12
        end else if (!c.bias_above_start) begin
          n.st = seq_pkg::S_IDLE; // RULE22
        end else begin
          n.tmr = r.tmr;
        end
      end
      default: n.st = seq_pkg::S_IDLE;
    endcase
    if (n.st == seq_pkg::S_UV_HOLD && r.st != seq_pkg::S_UV_HOLD) begin
      n.tmr = '0;
      ev_set[seq_pkg::EV_UV_BIT] = 1'b1;
    end
    if (n.st != r.st && n.st != seq_pkg::S_UV_HOLD) begin
      n.tmr = '0;
    end

    // write address and data are taken in either order
    if (axi_req.awvalid && aw_rdy) begin
      n.aw_hold = 1'b1;
      n.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && w_rdy) begin
      n.w_hold = 1'b1;
      n.wdata = axi_req.wdata;
      n.wstrb = axi_req.wstrb;
    end
    if (r.aw_hold && r.w_hold) begin
      n.aw_hold = 1'b0;
      n.w_hold = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = addr_hit(r.awaddr) ? seq_pkg::RESP_OKAY : seq_pkg::RESP_SLVERR;
      case (r.awaddr)
        seq_pkg::ADDR_CTRL: begin
          wm = merge(ctrl_w, r.wdata, r.wstrb);
          n.ext_drv = wm[seq_pkg::CTRL_EXT_BIT];
          n.sw_en = wm[seq_pkg::CTRL_EN_BIT];
        end
        seq_pkg::ADDR_HALF: begin
          wm = merge({16'h0000, r.half}, r.wdata, r.wstrb);
          n.half = wm[15:0];
        end
        seq_pkg::ADDR_DEAD: begin
          wm = merge({24'h00_0000, r.dead}, r.wdata, r.wstrb);
          n.dead = wm[7:0];
        end
        seq_pkg::ADDR_EVENT: begin
          ev_clr = r.wdata[1:0] & {2{r.wstrb[0]}};
        end
        default: wm = 32'h0000_0000;
      endcase
    end
    if (r.bvalid && axi_req.bready) begin
      n.bvalid = 1'b0;
    end

    // read: one cycle to rvalid, held until rready
    if (axi_req.arvalid && ar_rdy) begin
      n.rvalid = 1'b1;
      n.rresp = addr_hit(axi_req.araddr) ? seq_pkg::RESP_OKAY : seq_pkg::RESP_SLVERR;
      case (axi_req.araddr)
        seq_pkg::ADDR_CTRL: n.rdata = ctrl_w;
        seq_pkg::ADDR_HALF: n.rdata = {16'h0000, r.half};
        seq_pkg::ADDR_DEAD: n.rdata = {24'h00_0000, r.dead};
        seq_pkg::ADDR_STATUS: n.rdata = stat_w;
        seq_pkg::ADDR_EVENT: n.rdata = {30'h0000_0000, r.ev};
        default: n.rdata = 32'h0000_0000;
      endcase
    end else if (r.rvalid && axi_req.rready) begin
      n.rvalid = 1'b0;
    end

    // sticky events: a new event wins over a clear in the same cycle
    n.ev = (r.ev & ~ev_clr) | ev_set;
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
      r.fet <= 1'b1;
      r.sw_en <= 1'b1;
      r.half <= seq_pkg::HALF_RST;
      r.dead <= seq_pkg::DEAD_RST;
    end else begin
      r <= n;
    end
  end

  // gate pulse trains follow the llc enable
  gate_pulse_gen u_pulse (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .run(r.llc),
    .half_period(r.half),
    .dead_time(r.dead),
    .gate_out_first(gate_out_first),
    .gate_out_second(gate_out_second),
    .busy(burst)
  );

  assign startup_fet_gate = r.fet;
  assign pfc_run = r.pfc;
  assign llc_run = r.llc;
  assign axi_rsp.awready = aw_rdy;
  assign axi_rsp.wready = w_rdy;
  assign axi_rsp.bvalid = r.bvalid;
  assign axi_rsp.bresp = r.bresp;
  assign axi_rsp.arready = ar_rdy;
  assign axi_rsp.rvalid = r.rvalid;
  assign axi_rsp.rdata = r.rdata;
  assign axi_rsp.rresp = r.rresp;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  a_fet_off_start: assert property ( // RULE7
    (r.st == seq_pkg::S_IDLE && c.bias_above_start) |=> (!r.fet && r.st == seq_pkg::S_SAMPLE))
    else $error("fet not switched off at start threshold");
  a_aux_select: assert property ( // RULE1
    (r.st == seq_pkg::S_SAMPLE && c.bias_above_start && c.pin_below_selsb &&
     r.tmr == TW'(SAMPLE_CYC - 1)) |=> (!r.mode_self && r.st == seq_pkg::S_AUX_WAIT))
    else $error("aux mode not selected after sampling");
  a_pfc_level: assert property ( // RULE2
    (r.pfc && !r.mode_self) |-> $past(c.pin_above_first_run))
    else $error("pfc running without run level");
  a_llc_level: assert property ( // RULE3
    (r.llc && !r.mode_self) |-> ($past(c.pin_above_both_run) && r.pfc))
    else $error("llc running without both run level");
  a_ramp_time: assert property ( // RULE6
    (r.st == seq_pkg::S_AUX_RUN && $past(r.st) == seq_pkg::S_AUX_RAMP)
    |-> $past(r.tmr) == TW'(START_CYC - 1))
    else $error("start delay wrong length");
  a_uv_stop: assert property ( // RULE11
    ((r.st == seq_pkg::S_SB_RUN && (!c.bias_above_sb_uv || !c.bias_above_sb_stop)) ||
     (r.st == seq_pkg::S_AUX_RUN && !c.bias_above_ab_uv)) |=> (!r.pfc && !r.llc))
    else $error("stages not stopped on undervoltage");
  a_uv_hold: assert property ( // RULE21
    (r.st == seq_pkg::S_UV_HOLD && r.tmr < TW'(RESTART_CYC - 1))
    |=> (r.st == seq_pkg::S_UV_HOLD && !r.pfc && !r.llc))
    else $error("left undervoltage hold early");
  a_sb_recharge: assert property ( // RULE13
    (r.st == seq_pkg::S_UV_HOLD && r.mode_self && r.tmr == TW'(RESTART_CYC - 1))
    |=> (r.fet && r.st == seq_pkg::S_SB_CHARGE))
    else $error("self bias recharge not started");
endmodule

//--- shared/seq_pkg.sv
// Behaviour
// RULE1: pin below select level through the sampling time after start selects aux bias
// RULE2: aux bias, pin between first and both run levels runs pfc only
// RULE3: aux bias, pin above both run level runs pfc and llc
// RULE4: external source keeps pin low 10 ms after start; slow rc otherwise
// RULE5: system applies line first, holds pin low while bias rises
// RULE6: aux bias start-up completes 150 to 250 ms after pin raised
// RULE7: bias reaching start threshold drives start-up fet gate low
// RULE8: pin tied to bias selects self bias and turns the fet on again
// RULE9: self bias, at charge level fet off; pfc starts if line and bulk qualify
// RULE10: self bias keeps both stages switching while bias above stop level
// RULE11: bias below the active mode undervoltage level stops both stages
// RULE12: aux bias undervoltage, wait for rail above aux stop, then restart
// RULE13: self bias undervoltage, fet on, recharge to charge level, restart
// RULE14: gate outputs symmetric, 180 degrees apart, duty below 50 percent
// RULE15: steady state gate duty cycles matched
// RULE16: first pulse half width on first gate, last half width on second
// RULE17: transformer drive uses first gate high side; external driver reversed
// RULE18: external driver follows inputs, outputs low in its undervoltage
// RULE19: external high-side driver waits about 20 us before high pulses
// RULE20: smooth start counts only with transformer drive
// RULE21: bias undervoltage is a short fault recovering after 100 ms
// RULE22: bias mode latched once per power-up until rail restarts; self bias never returns to S_IDLE and stays latched until reset
package seq_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned T_MODE_SAMPLE_MS = 10;
  localparam int unsigned T_START_MS = 150;
  localparam int unsigned T_RESTART_MS = 100;
  localparam int unsigned MODE_SAMPLE_CYC = T_MODE_SAMPLE_MS * (CLK_HZ / 1000);
  localparam int unsigned START_DELAY_CYC = T_START_MS * (CLK_HZ / 1000);
  localparam int unsigned RESTART_CYC = T_RESTART_MS * (CLK_HZ / 1000);
  localparam int TMR_W = 25;

  // ---------------------------------------------------------------
  // register map, fields and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_HALF = 8'h04;
  localparam logic [7:0] ADDR_DEAD = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_EVENT = 8'h10;
  localparam int CTRL_EXT_BIT = 0;
  localparam int CTRL_EN_BIT = 1;
  localparam int ST_MODE_BIT = 0;
  localparam int ST_FET_BIT = 1;
  localparam int ST_PFC_BIT = 2;
  localparam int ST_LLC_BIT = 3;
  localparam int ST_SMOOTH_BIT = 4;
  localparam int ST_BURST_BIT = 5;
  localparam int ST_STATE_LSB = 8;
  localparam int EV_UV_BIT = 0;
  localparam int EV_RUN_BIT = 1;
  localparam logic [15:0] HALF_RST = 16'h01F4;
  localparam logic [7:0] DEAD_RST = 8'h14;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE, S_SAMPLE, S_AUX_WAIT, S_AUX_RAMP, S_AUX_RUN,
    S_SB_CHARGE, S_SB_QUAL, S_SB_RUN, S_UV_HOLD
  } seq_state_e;

  typedef struct packed {
    logic bias_above_start;
    logic bias_above_sb_charge;
    logic bias_above_sb_stop;
    logic bias_above_ab_uv;
    logic bias_above_sb_uv;
    logic pin_below_selsb;
    logic pin_above_first_run;
    logic pin_above_both_run;
    logic line_current_ok;
    logic bulk_above_peak;
  } cmp_s;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } axil_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_s;
endpackage

//--- rtl/gate_pulse_gen.sv
`timescale 1ns/100ps
module gate_pulse_gen (
  // clock and reset
  input logic ref_clk,
  input logic rstn,
  // burst request and timing
  input logic run,
  input logic [15:0] half_period,
  input logic [7:0] dead_time,
  // gate drive
  output logic gate_out_first,
  output logic gate_out_second,
  output logic busy
);
  typedef enum logic [1:0] {P_IDLE, P_RUN, P_LAST} phase_e;
  typedef struct packed {
    phase_e ph;
    logic side;
    logic [15:0] cnt;
    logic [15:0] hp;
    logic [15:0] width;
    logic g1;
    logic g2;
  } pulse_s;

  pulse_s r;
  pulse_s n;
  logic [15:0] on_w;
  logic [15:0] half_w;

  // slot sequencer: one slot per half period, sides alternate
  always_comb begin
    logic [7:0] dead_e;
    dead_e = (dead_time == 8'h00) ? 8'h01 : dead_time;
    // pulse shorter than the slot for any half period above 1, so duty stays under half
    on_w = (half_period > {8'h00, dead_e}) ? half_period - {8'h00, dead_e} : 16'h0001; // RULE14
    half_w = (on_w > 16'h0001) ? {1'b0, on_w[15:1]} : 16'h0001;
    n = r;
    n.cnt = r.cnt + 16'h0001;
    case (r.ph)
      P_IDLE: begin
        n.cnt = 16'h0000;
        if (run) begin
          n.ph = P_RUN;
          n.side = 1'b0; // RULE16
          n.hp = half_period;
          n.width = half_w;
        end
      end
      P_RUN: begin
        if (r.cnt == r.hp - 16'h0001) begin
          n.cnt = 16'h0000;
          n.hp = half_period;
          n.side = ~r.side;
          n.width = on_w; // RULE15
          if (!run && !r.side) begin
            n.ph = P_LAST;
            n.width = half_w; // RULE16
          end
        end
      end
      P_LAST: begin
        if (r.cnt == r.hp - 16'h0001) begin
          n.ph = P_IDLE;
          n.cnt = 16'h0000;
        end
      end
      default: n.ph = P_IDLE;
    endcase
    n.g1 = (n.ph != P_IDLE) && !n.side && (n.cnt < n.width); // RULE14
    n.g2 = (n.ph != P_IDLE) && n.side && (n.cnt < n.width);
  end

  // state register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign gate_out_first = r.g1;
  assign gate_out_second = r.g2;
  assign busy = (r.ph != P_IDLE);

  a_no_overlap: assert property (@(posedge ref_clk) disable iff (!rstn) // RULE14
    !(r.g1 && r.g2)) else $error("both gate outputs high");
  a_first_half: assert property (@(posedge ref_clk) disable iff (!rstn) // RULE16
    (r.ph == P_IDLE && run) |=> (r.g1 && !r.side && r.width == $past(half_w)))
    else $error("burst did not open with half pulse on first gate");
  a_last_second: assert property (@(posedge ref_clk) disable iff (!rstn) // RULE16
    (r.ph == P_RUN && !run && !r.side && r.cnt == r.hp - 16'h0001)
    |=> (r.ph == P_LAST && r.side && r.width == $past(half_w)))
    else $error("burst did not close with half pulse on second gate");
endmodule

//--- tb/hb_driver_model.sv
`timescale 1ns/100ps
// ------------------------------
// external half-bridge driver
// ------------------------------
module hb_driver_model #(
  parameter int HS_DELAY = 8
) (
  // clock
  input wire logic ref_clk,
  // supply and logic inputs
  input wire logic supply_ok,
  input wire logic driver_high_input,
  input wire logic driver_low_input,
  // switch drive
  output logic driver_high_output,
  output logic driver_low_output
);
  int hs_cnt;
  // bootstrap settle: high side stays quiet until the delay has run out
  always @(posedge ref_clk) begin
    if (!supply_ok) begin
      hs_cnt <= 0;
    end else if (hs_cnt < HS_DELAY) begin
      hs_cnt <= hs_cnt + 1;
    end
  end
  // outputs follow the inputs when active and are held low in undervoltage
  assign driver_low_output = supply_ok & driver_low_input;
  assign driver_high_output = supply_ok & (hs_cnt >= HS_DELAY) & driver_high_input;
endmodule

//--- tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  // ------------------------------
  // signals
  // ------------------------------
  logic ref_clk, rstn, fet, pfc, llc, g1, g2, drv_ok, ho, lo;
  logic lastg = 1'b0;
  seq_pkg::axil_req_s req;
  seq_pkg::axil_rsp_s rsp;
  seq_pkg::cmp_s cmp;
  int err_count, n_checks, c1, c2, w1, w2, both_hi, lo_hi, ho_hi;
  // short counts keep the run brief; expectations derive from these
  localparam int SMP = 20;
  localparam int STC = 30;
  localparam int RSC = 25;

  dual_stage_start_sequencer #(.SAMPLE_CYC(SMP), .START_CYC(STC), .RESTART_CYC(RSC)) uut (
    .ref_clk(ref_clk), .rstn(rstn), .axi_req(req), .axi_rsp(rsp), .cmp_raw(cmp),
    .startup_fet_gate(fet), .pfc_run(pfc), .llc_run(llc),
    .gate_out_first(g1), .gate_out_second(g2));

  // driver device wiring: first gate feeds the low side
  hb_driver_model drv (.ref_clk(ref_clk), .supply_ok(drv_ok), .driver_low_input(g1),
    .driver_high_input(g2), .driver_high_output(ho), .driver_low_output(lo));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // pulse widths, last gate to pulse and overlap, for the burst checks
  always @(posedge ref_clk) begin
    if (g1) c1++; else if (c1 > 0) begin w1 = c1; c1 = 0; lastg = 1'b0; end
    if (g2) c2++; else if (c2 > 0) begin w2 = c2; c2 = 0; lastg = 1'b1; end
    if (g1 && g2) both_hi++;
    if (lo) lo_hi++;
    if (ho) ho_hi++;
  end

  // ------------------------------
  // helpers
  // ------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic wait_lvl(ref logic s, input logic v, input int lim, output int n);
    n = 0;
    while (s !== v && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid);
    req.bready <= 1'b0;
    r = rsp.bresp;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid);
    req.rready <= 1'b0;
    d = rsp.rdata;
    r = rsp.rresp;
  endtask

  task automatic do_reset;
    rstn <= 1'b0;
    cmp <= '0;
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
  endtask

  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic t_ext;
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(seq_pkg::ADDR_STATUS, d, r);
    chk("smooth default", 1, d[seq_pkg::ST_SMOOTH_BIT]);
    axi_rd(seq_pkg::ADDR_HALF, d, r);
    chk("half reset", seq_pkg::HALF_RST, d);
    axi_wr(seq_pkg::ADDR_CTRL, 32'h3, r);
    chk("ctrl resp", seq_pkg::RESP_OKAY, r);
    axi_wr(8'h14, 32'h0, r);
    chk("unmapped resp", seq_pkg::RESP_SLVERR, r);
    axi_rd(seq_pkg::ADDR_STATUS, d, r);
    chk("smooth off", 0, d[seq_pkg::ST_SMOOTH_BIT]);
    axi_wr(seq_pkg::ADDR_CTRL, 32'h2, r);
  endtask

  task automatic t_aux;
    int n, m;
    logic [31:0] d;
    logic [1:0] r;
    // pin held low while the rail comes up
    cmp.bias_above_start <= 1'b1;
    cmp.bias_above_ab_uv <= 1'b1;
    cmp.pin_below_selsb <= 1'b1;
    wait_lvl(fet, 1'b0, 10, n);
    chk("fet off at start", 0, fet);
    repeat (SMP + 8) @(posedge ref_clk);
    axi_rd(seq_pkg::ADDR_STATUS, d, r);
    chk("aux state", 32'h200, d & 32'hF01);
    axi_wr(seq_pkg::ADDR_HALF, 32'h28, r);
    axi_wr(seq_pkg::ADDR_DEAD, 32'h4, r);
    cmp.pin_above_first_run <= 1'b1;
    wait_lvl(pfc, 1'b1, STC + 20, n);
    chk("pfc delay", 1, n >= STC && n <= STC + 8);
    chk("pfc only", 0, llc);
    cmp.pin_above_both_run <= 1'b1;
    wait_lvl(llc, 1'b1, 10, n);
    chk("both run", 1, llc);
    w1 = 0;
    w2 = 0;
    repeat (45) @(posedge ref_clk);
    chk("first half", 18, w1);
    chk("second idle", 0, w2);
    chk("driver held low", 0, lo_hi);
    drv_ok <= 1'b1;
    repeat (85) @(posedge ref_clk);
    chk("second width", 36, w2);
    chk("first width", 36, w1);
    chk("overlap", 0, both_hi);
    chk("low side width", 36, lo_hi);
    chk("high side delayed", 1, ho_hi > 0 && ho_hi < 72);
    cmp.pin_above_both_run <= 1'b0;
    wait_lvl(llc, 1'b0, 10, n);
    repeat (120) @(posedge ref_clk);
    chk("last gate", 1, lastg);
    chk("last half", 18, w2);
    chk("pfc stays", 1, pfc);
    // rail dip in a full run, then recovery
    cmp.pin_above_both_run <= 1'b1;
    wait_lvl(llc, 1'b1, 10, n);
    cmp.bias_above_ab_uv <= 1'b0;
    wait_lvl(pfc, 1'b0, 8, n);
    chk("uv pfc", 0, pfc);
    chk("uv llc", 0, llc);
    cmp.bias_above_ab_uv <= 1'b1;
    wait_lvl(pfc, 1'b1, RSC + STC + 30, m);
    chk("aux restart", 1, n + m >= RSC + STC && n + m <= RSC + STC + 16);
    axi_rd(seq_pkg::ADDR_EVENT, d, r);
    chk("events set", 3, d);
    axi_wr(seq_pkg::ADDR_EVENT, 32'h3, r);
    axi_rd(seq_pkg::ADDR_EVENT, d, r);
    chk("events cleared", 0, d);
  endtask

  task automatic t_self;
    int n;
    logic [31:0] d;
    logic [1:0] r;
    cmp.bias_above_start <= 1'b1;
    cmp.bias_above_sb_stop <= 1'b1;
    cmp.bias_above_sb_uv <= 1'b1;
    wait_lvl(fet, 1'b0, 10, n);
    wait_lvl(fet, 1'b1, 10, n);
    chk("fet back on", 1, fet);
    axi_rd(seq_pkg::ADDR_STATUS, d, r);
    chk("self mode", 1, d[seq_pkg::ST_MODE_BIT]);
    cmp.bias_above_sb_charge <= 1'b1;
    wait_lvl(fet, 1'b0, 10, n);
    chk("fet off charged", 0, fet);
    repeat (20) @(posedge ref_clk);
    chk("no line no pfc", 0, pfc);
    cmp.line_current_ok <= 1'b1;
    cmp.bulk_above_peak <= 1'b1;
    wait_lvl(llc, 1'b1, 10, n);
    chk("both switching", 3, {pfc, llc});
    cmp.bias_above_sb_stop <= 1'b0;
    wait_lvl(pfc, 1'b0, 8, n);
    chk("stop level", 0, llc);
    cmp.bias_above_sb_stop <= 1'b1;
    cmp.bias_above_sb_charge <= 1'b0;
    wait_lvl(fet, 1'b1, RSC + 10, n);
    chk("recharge fet", 1, n >= RSC - 2 && n <= RSC + 6);
    repeat (10) @(posedge ref_clk);
    chk("wait charge", 0, pfc);
    cmp.bias_above_sb_charge <= 1'b1;
    wait_lvl(pfc, 1'b1, 12, n);
    chk("restarted", 1, pfc);
  endtask

  // ------------------------------
  // sequence and verdict
  // ------------------------------
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    rstn = 1'b0;
    req = '0;
    cmp = '0;
    drv_ok = 1'b0;
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    t_ext;
    t_aux;
    do_reset;
    t_self;
    wrap_up;
  end

  // a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    wrap_up;
  end
endmodule
